// File: intc_pkg.sv
// Constants, register map and state types of the vectored interrupt controller.
package intc_pkg;
    localparam int NUM_SRC = 96;
    localparam int NUM_FLAG_REGS = 6;
    localparam int NUM_PRIO_REGS = 24;
    localparam int SRC_PER_PRIO = 4;
    localparam int NUM_EXT = 5;
    localparam int NUM_TRAP = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int VEC_W = 7;
    localparam int LVL_W = 4;
    localparam int PRIO_W = 3;
    localparam int VADDR_W = 24;

    localparam logic [ADDR_W-1:0] FLAG_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] EN_BASE = 8'h08;
    localparam logic [ADDR_W-1:0] PRIO_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] CTRL1_ADDR = 8'h30;
    localparam logic [ADDR_W-1:0] CTRL2_ADDR = 8'h31;
    localparam logic [ADDR_W-1:0] PEND_ADDR = 8'h32;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h33;
    localparam logic [ADDR_W-1:0] CORE_ADDR = 8'h34;

    localparam int NEST_DIS_BIT = 15;
    localparam int TRAP_LSB = 1;
    localparam int ALT_SEL_BIT = 15;
    localparam int IPL_LSB = 5;
    localparam int CPU_PRIORITY_HIGH_BIT_BIT = 3;
    localparam int PEND_LVL_LSB = 8;

    localparam logic [VADDR_W-1:0] PRIMARY_BASE = 24'h000014;
    localparam logic [VADDR_W-1:0] ALT_OFFSET = 24'h000100;
    localparam logic [2:0] IPL_BLOCK_ALL = 3'h7;

    // External pin k feeds the source with this vector number.
    localparam logic [NUM_EXT-1:0][VEC_W-1:0] EXT_VEC = {7'h36, 7'h35, 7'h1d, 7'h14, 7'h00};

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [NUM_SRC-1:0] flags;
        logic [NUM_SRC-1:0] en;
        logic [NUM_SRC*PRIO_W-1:0] prio;
        logic nest_dis;
        logic [NUM_TRAP-1:0] trap;
        logic alt_sel;
        logic [NUM_EXT-1:0] ext_pol;
        logic [2:0] cpu_priority_low_bits;
        logic cpu_priority_high_bit;
        logic [VEC_W-1:0] vec_num;
        logic [LVL_W-1:0] pend_lvl;
        logic irq;
        logic [VADDR_W-1:0] vec_addr;
        logic [DATA_W-1:0] rd_data;
        logic [NUM_EXT-1:0] ext_s1;
        logic [NUM_EXT-1:0] ext_s2;
        logic [NUM_EXT-1:0] ext_d;
    } intc_state_t;

    localparam intc_state_t STATE_RST = '0;
endpackage

// File: intc_top.sv
// Vectored priority interrupt controller with register port.
`timescale 1ns/1ps
`default_nettype none
module intc_top (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire intc_pkg::reg_req_t req_in,
    input wire logic [intc_pkg::NUM_SRC-1:0] src_req_in,
    input wire logic [intc_pkg::NUM_EXT-1:0] ext_pin_in,
    input wire logic [intc_pkg::NUM_TRAP-1:0] trap_event_in,
    input wire logic cpu_priority_high_bit_set_in,
    output logic [intc_pkg::DATA_W-1:0] rd_data_out,
    output logic irq_out,
    output logic [intc_pkg::VEC_W-1:0] vec_num_out,
    output logic [intc_pkg::LVL_W-1:0] pend_level_out,
    output logic [intc_pkg::VADDR_W-1:0] vec_addr_out,
    output logic [intc_pkg::LVL_W-1:0] cpu_level_out,
    output logic nest_dis_out
);
    intc_pkg::intc_state_t st_r;
    intc_pkg::intc_state_t st_nxt;
    logic [intc_pkg::NUM_SRC-1:0] ext_set;
    logic [intc_pkg::NUM_EXT-1:0] ext_edge;
    logic [intc_pkg::LVL_W-1:0] cpu_lvl;

    assign cpu_lvl = {st_r.cpu_priority_high_bit, st_r.cpu_priority_low_bits};

    // Synchronised pin edges, polarity chosen per pin.
    genvar g;
    generate
        for (g = 0; g < intc_pkg::NUM_EXT; g++) begin : g_ext
            assign ext_edge[g] = st_r.ext_pol[g] ? (st_r.ext_d[g] & ~st_r.ext_s2[g]) :
                                 (~st_r.ext_d[g] & st_r.ext_s2[g]);
        end
        for (g = 0; g < intc_pkg::NUM_SRC; g++) begin : g_src
            always_comb begin
                ext_set[g] = 1'b0;
                for (int k = 0; k < intc_pkg::NUM_EXT; k++) begin
                    if (intc_pkg::EXT_VEC[k] == 7'(g)) begin
                        ext_set[g] = ext_edge[k];
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        logic [intc_pkg::DATA_W-1:0] rv;
        logic found;
        logic [intc_pkg::PRIO_W-1:0] best_lvl;
        logic [intc_pkg::VEC_W-1:0] best_idx;
        logic [intc_pkg::PRIO_W-1:0] p;
        logic [intc_pkg::VADDR_W-1:0] base;
        rv = '0;
        found = 1'b0;
        best_lvl = '0;
        best_idx = '0;
        p = '0;
        base = '0;
        st_nxt = st_r;

        st_nxt.ext_s1 = ext_pin_in;
        st_nxt.ext_s2 = st_r.ext_s1;
        st_nxt.ext_d = st_r.ext_s2;

        if (req_in.wr) begin
            for (int r = 0; r < intc_pkg::NUM_FLAG_REGS; r++) begin
                if (req_in.addr == intc_pkg::FLAG_BASE + 8'(r)) begin
                    st_nxt.flags[r*intc_pkg::DATA_W +: intc_pkg::DATA_W] = req_in.wdata;
                end
                if (req_in.addr == intc_pkg::EN_BASE + 8'(r)) begin
                    st_nxt.en[r*intc_pkg::DATA_W +: intc_pkg::DATA_W] = req_in.wdata;
                end
            end
            for (int r = 0; r < intc_pkg::NUM_PRIO_REGS; r++) begin
                if (req_in.addr == intc_pkg::PRIO_BASE + 8'(r)) begin
                    for (int k = 0; k < intc_pkg::SRC_PER_PRIO; k++) begin
                        st_nxt.prio[(r*intc_pkg::SRC_PER_PRIO+k)*intc_pkg::PRIO_W +:
                                    intc_pkg::PRIO_W] = req_in.wdata[k*4 +: 3];
                    end
                end
            end
            if (req_in.addr == intc_pkg::CTRL1_ADDR) begin
                st_nxt.nest_dis = req_in.wdata[intc_pkg::NEST_DIS_BIT];
                st_nxt.trap = req_in.wdata[intc_pkg::TRAP_LSB +: intc_pkg::NUM_TRAP];
            end
            if (req_in.addr == intc_pkg::CTRL2_ADDR) begin
                st_nxt.alt_sel = req_in.wdata[intc_pkg::ALT_SEL_BIT];
                st_nxt.ext_pol = req_in.wdata[intc_pkg::NUM_EXT-1:0];
            end
            if (req_in.addr == intc_pkg::STATUS_ADDR && !st_r.nest_dis) begin
                st_nxt.cpu_priority_low_bits = req_in.wdata[intc_pkg::IPL_LSB +: 3];
            end
            if (req_in.addr == intc_pkg::CORE_ADDR && !req_in.wdata[intc_pkg::CPU_PRIORITY_HIGH_BIT_BIT]) begin
                st_nxt.cpu_priority_high_bit = 1'b0;
            end
        end

        // Hardware events are ORed in after the writes so a set beats a clear.
        st_nxt.flags = st_nxt.flags | src_req_in | ext_set;
        st_nxt.trap = st_nxt.trap | trap_event_in;
        if (cpu_priority_high_bit_set_in) begin
            st_nxt.cpu_priority_high_bit = 1'b1;
        end

        // Descending scan with >= leaves the lowest vector on a tie.
        for (int i = intc_pkg::NUM_SRC - 1; i >= 0; i--) begin
            p = st_r.prio[i*intc_pkg::PRIO_W +: intc_pkg::PRIO_W];
            if (st_r.flags[i] && st_r.en[i] && ({1'b0, p} > cpu_lvl) &&
                (!found || p >= best_lvl)) begin
                found = 1'b1;
                best_lvl = p;
                best_idx = 7'(i);
            end
        end
        st_nxt.irq = found;
        if (found) begin
            st_nxt.vec_num = best_idx;
            st_nxt.pend_lvl = {1'b0, best_lvl};
            base = intc_pkg::PRIMARY_BASE + {16'h0000, best_idx, 1'b0};
            st_nxt.vec_addr = st_r.alt_sel ? base + intc_pkg::ALT_OFFSET : base;
        end

        for (int r = 0; r < intc_pkg::NUM_FLAG_REGS; r++) begin
            if (req_in.addr == intc_pkg::FLAG_BASE + 8'(r)) begin
                rv = st_r.flags[r*intc_pkg::DATA_W +: intc_pkg::DATA_W];
            end
            if (req_in.addr == intc_pkg::EN_BASE + 8'(r)) begin
                rv = st_r.en[r*intc_pkg::DATA_W +: intc_pkg::DATA_W];
            end
        end
        for (int r = 0; r < intc_pkg::NUM_PRIO_REGS; r++) begin
            if (req_in.addr == intc_pkg::PRIO_BASE + 8'(r)) begin
                for (int k = 0; k < intc_pkg::SRC_PER_PRIO; k++) begin
                    rv[k*4 +: 3] = st_r.prio[(r*intc_pkg::SRC_PER_PRIO+k)*intc_pkg::PRIO_W +:
                                             intc_pkg::PRIO_W];
                end
            end
        end
        if (req_in.addr == intc_pkg::CTRL1_ADDR) begin
            rv[intc_pkg::NEST_DIS_BIT] = st_r.nest_dis;
            rv[intc_pkg::TRAP_LSB +: intc_pkg::NUM_TRAP] = st_r.trap;
        end
        if (req_in.addr == intc_pkg::CTRL2_ADDR) begin
            rv[intc_pkg::ALT_SEL_BIT] = st_r.alt_sel;
            rv[intc_pkg::NUM_EXT-1:0] = st_r.ext_pol;
        end
        if (req_in.addr == intc_pkg::PEND_ADDR) begin
            rv[intc_pkg::PEND_LVL_LSB +: intc_pkg::LVL_W] = st_r.pend_lvl;
            rv[intc_pkg::VEC_W-1:0] = st_r.vec_num;
        end
        if (req_in.addr == intc_pkg::STATUS_ADDR) begin
            rv[intc_pkg::IPL_LSB +: 3] = st_r.cpu_priority_low_bits;
        end
        if (req_in.addr == intc_pkg::CORE_ADDR) begin
            rv[intc_pkg::CPU_PRIORITY_HIGH_BIT_BIT] = st_r.cpu_priority_high_bit;
        end
        // Unmapped addresses read as zero; read data lasts one cycle only.
        st_nxt.rd_data = req_in.rd ? rv : '0;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            st_r <= intc_pkg::STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_out = st_r.rd_data;
    assign irq_out = st_r.irq;
    assign vec_num_out = st_r.vec_num;
    assign pend_level_out = st_r.pend_lvl;
    assign vec_addr_out = st_r.vec_addr;
    assign cpu_level_out = cpu_lvl;
    assign nest_dis_out = st_r.nest_dis;

    a_flag_sticky: assert property (@(posedge mclk_in) disable iff (rst_in)
        (st_r.flags[0] && !(req_in.wr && req_in.addr == intc_pkg::FLAG_BASE)) |=> st_r.flags[0])
        else $error("request flag dropped without a clear");

    a_src_sets_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
        src_req_in[3] |=> st_r.flags[3])
        else $error("source event did not set its flag");

    a_none_enabled: assert property (@(posedge mclk_in) disable iff (rst_in)
        !(|(st_r.flags & st_r.en)) |=> !st_r.irq)
        else $error("request raised with nothing enabled");

    a_level_above_cpu: assert property (@(posedge mclk_in) disable iff (rst_in)
        st_r.irq |-> (st_r.pend_lvl > $past(cpu_lvl)))
        else $error("request not above cpu level");

    a_block_at_seven: assert property (@(posedge mclk_in) disable iff (rst_in)
        (st_r.cpu_priority_low_bits == intc_pkg::IPL_BLOCK_ALL) |=> !st_r.irq)
        else $error("user request at cpu level seven");

    a_vector_address: assert property (@(posedge mclk_in) disable iff (rst_in)
        st_r.irq |-> (st_r.vec_addr == intc_pkg::PRIMARY_BASE + {16'h0000, st_r.vec_num, 1'b0} +
                      ($past(st_r.alt_sel) ? intc_pkg::ALT_OFFSET : 24'h000000)))
        else $error("vector address does not match vector number");

    a_cpu_priority_high_bit_no_set: assert property (@(posedge mclk_in) disable iff (rst_in)
        (!st_r.cpu_priority_high_bit && !cpu_priority_high_bit_set_in) |=> !st_r.cpu_priority_high_bit)
        else $error("fourth level bit set without hardware cause");

    a_ipl_locked: assert property (@(posedge mclk_in) disable iff (rst_in)
        (st_r.nest_dis && req_in.wr && req_in.addr == intc_pkg::STATUS_ADDR) |=>
        (st_r.cpu_priority_low_bits == $past(st_r.cpu_priority_low_bits)))
        else $error("level bits changed while nesting disabled");

    a_trap_sets: assert property (@(posedge mclk_in) disable iff (rst_in)
        trap_event_in[2] |=> st_r.trap[2])
        else $error("address trap did not set its flag");

    a_ext_rise: assert property (@(posedge mclk_in) disable iff (rst_in)
        ($rose(ext_pin_in[0]) && !st_r.ext_pol[0] && !req_in.wr) ##1 (!req_in.wr)[*2] |->
        ##[0:1] st_r.flags[0])
        else $error("rising edge on pin zero not flagged");
endmodule
`default_nettype wire

// File: periph_core_model.sv
// Stand-in for the peripherals, external pins and core around the controller.
`timescale 1ns/1ps
`default_nettype none
module periph_core_model (
    input wire logic mclk_in,
    output logic [intc_pkg::NUM_SRC-1:0] src_req_out,
    output logic [intc_pkg::NUM_EXT-1:0] ext_pin_out,
    output logic [intc_pkg::NUM_TRAP-1:0] trap_out,
    output logic cpu_priority_high_bit_set_out
);
    initial begin
        src_req_out = '0;
        ext_pin_out = '0;
        trap_out = '0;
        cpu_priority_high_bit_set_out = 1'b0;
    end

    // Events are single-cycle pulses, the shortest a peripheral may give.
    task automatic fire_src(input int v);
        @(posedge mclk_in);
        src_req_out <= 96'h1 << v;
        @(posedge mclk_in);
        src_req_out <= '0;
    endtask

    task automatic fire_trap(input logic [3:0] t);
        @(posedge mclk_in);
        trap_out <= t;
        @(posedge mclk_in);
        trap_out <= '0;
    endtask

    task automatic fire_cpu_priority_high_bit;
        @(posedge mclk_in);
        cpu_priority_high_bit_set_out <= 1'b1;
        @(posedge mclk_in);
        cpu_priority_high_bit_set_out <= 1'b0;
    endtask

    task automatic set_pin(input int k, input logic l);
        @(posedge mclk_in);
        ext_pin_out[k] <= l;
    endtask
endmodule
`default_nettype wire

// File: vectored_priority_interrupt_ctrl_tb_top.sv
// Self-checking bench for the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module vectored_priority_interrupt_ctrl_tb_top;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    intc_pkg::reg_req_t req = '0;
    logic [95:0] src;
    logic [4:0] pin;
    logic [3:0] trp;
    logic ip3;
    logic [15:0] rdd;
    logic irq;
    logic [6:0] vec;
    logic [3:0] lvl;
    logic [23:0] vad;
    logic [3:0] cpl;
    logic nst;
    int n_mismatch = 0;
    int tests_run = 0;
    logic rd_seen = 1'b0;
    logic [15:0] exp_q[$];
    logic [31:0] sd = 32'haa6ecffb;
    logic [7:0] ra[6] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'hff};

    always #2.5 mclk_in = ~mclk_in;

    intc_top u_intc_top (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(req),
        .src_req_in(src), .ext_pin_in(pin), .trap_event_in(trp), .cpu_priority_high_bit_set_in(ip3),
        .rd_data_out(rdd), .irq_out(irq), .vec_num_out(vec), .pend_level_out(lvl),
        .vec_addr_out(vad), .cpu_level_out(cpl), .nest_dis_out(nst));
    periph_core_model u_periph_core_model (.mclk_in(mclk_in), .src_req_out(src),
        .ext_pin_out(pin), .trap_out(trp), .cpu_priority_high_bit_set_out(ip3));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Wide enough for the largest packed output group, so no compared bit is cut off.
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A gap cycle between accesses keeps each strobe assigned once per step.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        req <= {a, d, 1'b1, 1'b0};
        @(posedge mclk_in);
        req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge mclk_in);
        req <= {a, 16'h0, 1'b0, 1'b1};
        @(posedge mclk_in);
        req <= '0;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask

    // Read data stand only in the cycle after the strobe, so sample exactly there.
    always @(posedge mclk_in) begin
        if (rd_seen) begin
            chk(rdd, exp_q.pop_front());
        end
        rd_seen <= req.rd;
    end

    initial begin
        #200000;
        n_mismatch++;
        complete_run;
    end

    initial begin
        repeat (4) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 6; i++) rd(ra[i], 16'h0);
        for (int i = 0; i < 6; i++) begin
            sd = lfsr(sd);
            wr(8'h08 + 8'(i), sd[15:0]);
            rd(8'h08 + 8'(i), sd[15:0]);
        end
        wr(8'h10, 16'h4000);
        wr(8'h08, 16'h0008);
        u_periph_core_model.fire_src(3);
        wt(3);
        chk({irq, vec, lvl, vad}, {1'b1, 7'h03, 4'h4, 24'h00001a});
        rd(8'h32, 16'h0403);
        rd(8'h00, 16'h0008);
        wr(8'h25, 16'h0400);
        wr(8'h0d, 16'h0040);
        u_periph_core_model.fire_src(86);
        wt(3);
        chk(vec, 7'h03);
        wr(8'h25, 16'h0500);
        wt(2);
        chk({vec, lvl, vad}, {7'h56, 4'h5, 24'h0000c0});
        wr(8'h31, 16'h8000);
        wt(2);
        chk(vad, 24'h0001c0);
        wr(8'h31, 16'h0000);
        wr(8'h33, 16'h00a0);
        wt(2);
        chk({cpl, irq}, {4'h5, 1'b0});
        rd(8'h33, 16'h00a0);
        wr(8'h33, 16'h0080);
        wt(2);
        chk({irq, vec}, {1'b1, 7'h56});
        wr(8'h33, 16'h00e0);
        wt(2);
        chk({cpl, irq}, {4'h7, 1'b0});
        wr(8'h33, 16'h0000);
        wr(8'h0d, 16'h0000);
        wt(2);
        chk({irq, vec}, {1'b1, 7'h03});
        wr(8'h08, 16'h0000);
        wt(2);
        chk(irq, 1'b0);
        rd(8'h05, 16'h0040);
        wr(8'h30, 16'h8000);
        wr(8'h33, 16'h00e0);
        wt(1);
        chk({nst, cpl}, {1'b1, 4'h0});
        rd(8'h33, 16'h0000);
        wr(8'h30, 16'h0000);
        u_periph_core_model.fire_cpu_priority_high_bit();
        wt(2);
        chk(cpl, 4'h8);
        wr(8'h34, 16'h0000);
        rd(8'h34, 16'h0000);
        wr(8'h34, 16'h0008);
        rd(8'h34, 16'h0000);
        u_periph_core_model.fire_trap(4'hf);
        rd(8'h30, 16'h001e);
        wr(8'h30, 16'h0000);
        rd(8'h30, 16'h0000);
        wr(8'h00, 16'h0000);
        u_periph_core_model.set_pin(0, 1'b1);
        wt(6);
        rd(8'h00, 16'h0001);
        wr(8'h31, 16'h0001);
        wr(8'h00, 16'h0000);
        u_periph_core_model.set_pin(0, 1'b0);
        wt(6);
        rd(8'h00, 16'h0001);
        wr(8'h00, 16'h0000);
        u_periph_core_model.set_pin(0, 1'b1);
        wt(6);
        rd(8'h00, 16'h0000);
        wt(3);
        complete_run;
    end
endmodule
`default_nettype wire
